// File: design/veoc_consts.vh
`ifndef VEOC_CONSTS_VH
`define VEOC_CONSTS_VH

// Event slots in the counter bank.
`define VEOC_EVENT_COUNT 16
`define VEOC_INC_W 8
`define VEOC_EV_SCALABLE_DOUBLE_FP_ELEMENT_OPS 0
`define VEOC_EV_FIXED_DOUBLE_FP_ELEMENT_OPS 1
`define VEOC_EV_SCALABLE_INTEGER_ELEMENT_OPS 2
`define VEOC_EV_FIXED_INTEGER_ELEMENT_OPS 3
`define VEOC_EV_SCALABLE_MEM_ACCESS_ELEMENT_OPS 4
`define VEOC_EV_FIXED_MEM_ACCESS_ELEMENT_OPS 5
`define VEOC_EV_SCALABLE_READ_ELEMENT_OPS 6
`define VEOC_EV_FIXED_READ_ELEMENT_OPS 7
`define VEOC_EV_SCALABLE_WRITE_ELEMENT_OPS 8
`define VEOC_EV_FIXED_WRITE_ELEMENT_OPS 9
`define VEOC_EV_SCALABLE_MEM_ACCESS_BYTES 10
`define VEOC_EV_FIXED_MEM_ACCESS_BYTES 11
`define VEOC_EV_SCALABLE_READ_BYTES 12
`define VEOC_EV_FIXED_READ_BYTES 13
`define VEOC_EV_SCALABLE_WRITE_BYTES 14
`define VEOC_EV_FIXED_WRITE_BYTES 15

// Architectural event numbers of the sixteen counters, in slot order.
`define VEOC_CODE_SCALABLE_DOUBLE_FP_ELEMENT_OPS 16'h80C6
`define VEOC_CODE_FIXED_DOUBLE_FP_ELEMENT_OPS 16'h80C7
`define VEOC_CODE_SCALABLE_INTEGER_ELEMENT_OPS 16'h80C8
`define VEOC_CODE_FIXED_INTEGER_ELEMENT_OPS 16'h80C9
`define VEOC_CODE_SCALABLE_MEM_ACCESS_ELEMENT_OPS 16'h80CA
`define VEOC_CODE_FIXED_MEM_ACCESS_ELEMENT_OPS 16'h80CB
`define VEOC_CODE_SCALABLE_READ_ELEMENT_OPS 16'h80CC
`define VEOC_CODE_FIXED_READ_ELEMENT_OPS 16'h80CD
`define VEOC_CODE_SCALABLE_WRITE_ELEMENT_OPS 16'h80CE
`define VEOC_CODE_FIXED_WRITE_ELEMENT_OPS 16'h80CF
`define VEOC_CODE_SCALABLE_MEM_ACCESS_BYTES 16'h80DA
`define VEOC_CODE_FIXED_MEM_ACCESS_BYTES 16'h80DB
`define VEOC_CODE_SCALABLE_READ_BYTES 16'h80DC
`define VEOC_CODE_FIXED_READ_BYTES 16'h80DD
`define VEOC_CODE_SCALABLE_WRITE_BYTES 16'h80DE
`define VEOC_CODE_FIXED_WRITE_BYTES 16'h80DF

// Operation classes issued by the pipeline.
`define VEOC_CLASS_NONE 2'h0
`define VEOC_CLASS_DOUBLE_FP 2'h1
`define VEOC_CLASS_INTEGER 2'h2
`define VEOC_CLASS_MEMORY 2'h3

// Memory transfer kinds.
`define VEOC_MEM_SINGLE_REGISTER 3'h0
`define VEOC_MEM_PAIR 3'h1
`define VEOC_MEM_ATOMIC_LOAD 3'h2
`define VEOC_MEM_ATOMIC_STORE 3'h3
`define VEOC_MEM_REPLICATING_LOAD 3'h4
`define VEOC_MEM_QUAD_REPLICATING_LOAD 3'h5
`define VEOC_MEM_MULTI_STRUCTURE 3'h6
`define VEOC_MEM_SCALABLE_VECTOR 3'h7

// Increment amounts.
`define VEOC_REFERENCE_BYTES 8'h10
`define VEOC_DOUBLE_SCALABLE_INC 8'h02
`define VEOC_DOUBLE_VECTOR_INC 8'h02
`define VEOC_SCALAR_INC 8'h01
`define VEOC_PAIR_INC 8'h02

`endif

// File: design/veoc_counter.v
`timescale 1ns/10ps
`default_nettype none
module veoc_counter #(
  parameter CNT_W = 64,
  parameter ADD_W = 12
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             clear,
  input  wire [ADD_W-1:0] add,
  output reg  [CNT_W-1:0] count
);
  reg [CNT_W-1:0] next_count;

  // Clear restarts from this cycle's increment, so an operation in the clear cycle is kept.
  always @* begin
    next_count = (clear ? {CNT_W{1'b0}} : count) + {{(CNT_W-ADD_W){1'b0}}, add};
  end

  always @(posedge clock) begin
    if (rst) begin
      count <= {CNT_W{1'b0}};
    end else begin
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

// File: design/veoc_event_counters.v
// Operation
// - Scalable double-precision op adds 2; fused multiply-add adds 4.
// - Fixed double-precision: vector adds 2, scalar 1, fused doubles; scalable excluded.
// - Scalable integer op adds 128/container size; multiply-add forms add twice.
// - Fixed integer: vector adds element count, scalar 1; multiply-accumulate doubles.
// - Scalable access elements: 128/container times registers; replicating loads excluded.
// - Fixed access elements: single 1, pair 2, atomics, replicating, quad, multi-structure.
// - Scalable read elements: 128/container times registers per vector load.
// - Fixed read elements: single 1, pair 2, atomic 1, replicating, quad, multi-structure.
// - Scalable write elements: 128/container times registers per vector store.
// - Fixed write elements: single 1, pair 2, atomic store 1, multi-structure.
// - Scalable access bytes: 16/(container/memory size) times registers, no replicating.
// - Fixed access bytes: memory size/8, doubled for pairs and atomic loads, quad 16.
// - Scalable read bytes: 16/(container/memory size) times registers per load.
// - Fixed read bytes: memory size/8 for single, atomic, replicating; pair doubles.
// - Scalable write bytes: 16/(container/memory size) times registers per store.
// - Fixed write bytes: memory size/8 single and atomic, pair doubles, multi-structure.
// - Scalable counts scale to 128-bit width; multiply-add counts two per element.
`timescale 1ns/10ps
`default_nettype none
`include "veoc_consts.vh"
module veoc_event_counters #(
  parameter SLOTS = 2,
  parameter CNT_W = 64,
  parameter SUM_W = 12
) (
  input  wire                              clock,
  input  wire                              rst,
  input  wire                              counter_clear,
  input  wire [SLOTS-1:0]                  slot_valid,
  input  wire [2*SLOTS-1:0]                slot_class,
  input  wire [SLOTS-1:0]                  slot_scalable,
  input  wire [SLOTS-1:0]                  slot_vector,
  input  wire [SLOTS-1:0]                  slot_fused,
  input  wire [3*SLOTS-1:0]                slot_mem_kind,
  input  wire [SLOTS-1:0]                  slot_store,
  input  wire [2*SLOTS-1:0]                slot_container_element_bits_log,
  input  wire [2*SLOTS-1:0]                slot_memory_element_bits_log,
  input  wire [5*SLOTS-1:0]                slot_fixed_elements,
  input  wire [3*SLOTS-1:0]                slot_registers,
  output reg  [`VEOC_EVENT_COUNT*SUM_W-1:0] cycle_increment,
  output wire [`VEOC_EVENT_COUNT*CNT_W-1:0] event_count
);
  localparam ALL_INC_W = `VEOC_EVENT_COUNT * `VEOC_INC_W;

  wire [SLOTS*ALL_INC_W-1:0]          slot_inc;
  reg  [`VEOC_EVENT_COUNT*SUM_W-1:0] next_cycle_increment;
  integer                            e;
  integer                            s;

  function [7:0] twice;
    input [7:0] value;
    begin
      twice = {value[6:0], 1'b0};
    end
  endfunction

  // Memory amounts of one operation, packed low to high as fixed read ops, fixed
  // write ops, fixed read bytes, fixed write bytes, then the same four for scalable.
  function [63:0] memory_increments;
    input       store;
    input [2:0] kind;
    input [1:0] csz;
    input [1:0] msz;
    input [4:0] elems;
    input [2:0] regs;

    reg [7:0] per_vec;
    reg [7:0] unit;
    reg [7:0] scl_bytes;
    reg [7:0] multi_ops;
    reg [7:0] multi_bytes;
    reg [7:0] ld_ops;
    reg [7:0] st_ops;
    reg [7:0] ld_bytes;
    reg [7:0] st_bytes;
    reg [7:0] sld_ops;
    reg [7:0] sst_ops;
    reg [7:0] sld_bytes;
    reg [7:0] sst_bytes;
    begin
      per_vec     = `VEOC_REFERENCE_BYTES >> csz;
      unit        = 8'h01 << msz;
      // A memory element wider than its container is malformed; count it as unpacked.
      scl_bytes = (msz <= csz) ? (`VEOC_REFERENCE_BYTES >> (csz - msz)) : `VEOC_REFERENCE_BYTES;
      multi_ops   = {3'h0, elems} * {5'h00, regs};
      multi_bytes = ({3'h0, elems} << msz) * {5'h00, regs};
      ld_ops      = 8'h00;
      st_ops      = 8'h00;
      ld_bytes    = 8'h00;
      st_bytes    = 8'h00;
      sld_ops     = 8'h00;
      sst_ops     = 8'h00;
      sld_bytes   = 8'h00;
      sst_bytes   = 8'h00;
      case (kind)
        `VEOC_MEM_SINGLE_REGISTER: begin
          ld_ops   = store ? 8'h00 : `VEOC_SCALAR_INC;
          ld_bytes = store ? 8'h00 : unit;
          st_ops   = store ? `VEOC_SCALAR_INC : 8'h00;
          st_bytes = store ? unit : 8'h00;
        end

        `VEOC_MEM_PAIR: begin
          ld_ops   = store ? 8'h00 : `VEOC_PAIR_INC;
          ld_bytes = store ? 8'h00 : twice(unit);
          st_ops   = store ? `VEOC_PAIR_INC : 8'h00;
          st_bytes = store ? twice(unit) : 8'h00;
        end

        `VEOC_MEM_ATOMIC_LOAD: begin
          // An atomic load reads and writes, so it feeds both halves and doubles the sum.
          // Atomic read-write.
          ld_ops   = `VEOC_SCALAR_INC;
          ld_bytes = unit;
          st_ops   = `VEOC_SCALAR_INC;
          st_bytes = unit;
        end

        `VEOC_MEM_ATOMIC_STORE: begin
          st_ops   = `VEOC_SCALAR_INC;
          st_bytes = unit;
        end

        `VEOC_MEM_REPLICATING_LOAD: begin
          ld_ops   = `VEOC_SCALAR_INC;
          ld_bytes = unit;
        end

        `VEOC_MEM_QUAD_REPLICATING_LOAD: begin
          ld_ops   = per_vec;
          ld_bytes = `VEOC_REFERENCE_BYTES;
        end

        `VEOC_MEM_MULTI_STRUCTURE: begin
          ld_ops   = store ? 8'h00 : multi_ops;
          ld_bytes = store ? 8'h00 : multi_bytes;
          st_ops   = store ? multi_ops : 8'h00;
          st_bytes = store ? multi_bytes : 8'h00;
        end

        default: begin
          sld_ops   = store ? 8'h00 : per_vec * {5'h00, regs};
          sld_bytes = store ? 8'h00 : scl_bytes * {5'h00, regs};
          sst_ops   = store ? per_vec * {5'h00, regs} : 8'h00;
          sst_bytes = store ? scl_bytes * {5'h00, regs} : 8'h00;
        end
      endcase
      memory_increments = {sst_bytes, sld_bytes, sst_ops, sld_ops,
                           st_bytes, ld_bytes, st_ops, ld_ops};
    end
  endfunction

  // Increments of one issued operation for all sixteen events.
  function [ALL_INC_W-1:0] slot_increments;
    input       valid;
    input [1:0] op_class;
    input       scalable;
    input       vector;
    input       fused;
    input [2:0] kind;
    input       store;
    input [1:0] csz;
    input [1:0] msz;
    input [4:0] elems;
    input [2:0] regs;
    reg [ALL_INC_W-1:0] r;
    reg [7:0]           per_vec;
    reg [7:0]           amount;
    reg [7:0]           ld_ops;
    reg [7:0]           st_ops;
    reg [7:0]           ld_bytes;
    reg [7:0]           st_bytes;
    reg [7:0]           sld_ops;
    reg [7:0]           sst_ops;
    reg [7:0]           sld_bytes;
    reg [7:0]           sst_bytes;
    begin
      r         = {ALL_INC_W{1'b0}};
      // Element counts are referred to a 128-bit vector whatever the real length.
      // Reference width scaling.
      per_vec   = `VEOC_REFERENCE_BYTES >> csz;
      ld_ops    = 8'h00;
      st_ops    = 8'h00;
      ld_bytes  = 8'h00;
      st_bytes  = 8'h00;
      sld_ops   = 8'h00;
      sst_ops   = 8'h00;
      sld_bytes = 8'h00;
      sst_bytes = 8'h00;
      amount    = 8'h00;
      if (valid && op_class == `VEOC_CLASS_DOUBLE_FP) begin
        if (scalable) begin
          amount = fused ? twice(`VEOC_DOUBLE_SCALABLE_INC) : `VEOC_DOUBLE_SCALABLE_INC;
          r[`VEOC_EV_SCALABLE_DOUBLE_FP_ELEMENT_OPS*8 +: 8] = amount;
        end else begin
          amount = vector ? `VEOC_DOUBLE_VECTOR_INC : `VEOC_SCALAR_INC;
          r[`VEOC_EV_FIXED_DOUBLE_FP_ELEMENT_OPS*8 +: 8] = fused ? twice(amount) : amount;
        end
      end
      if (valid && op_class == `VEOC_CLASS_INTEGER) begin
        if (scalable) begin
          r[`VEOC_EV_SCALABLE_INTEGER_ELEMENT_OPS*8 +: 8] = fused ? twice(per_vec) : per_vec;
        end else begin
          amount = vector ? {3'h0, elems} : `VEOC_SCALAR_INC;
          r[`VEOC_EV_FIXED_INTEGER_ELEMENT_OPS*8 +: 8] = fused ? twice(amount) : amount;
        end
      end
      if (valid && op_class == `VEOC_CLASS_MEMORY) begin
        {sst_bytes, sld_bytes, sst_ops, sld_ops, st_bytes, ld_bytes, st_ops, ld_ops} =
          memory_increments(store, kind, csz, msz, elems, regs);
      end
      r[`VEOC_EV_FIXED_READ_ELEMENT_OPS*8 +: 8]     = ld_ops;
      r[`VEOC_EV_FIXED_WRITE_ELEMENT_OPS*8 +: 8]    = st_ops;
      r[`VEOC_EV_FIXED_MEM_ACCESS_ELEMENT_OPS*8 +: 8] = ld_ops + st_ops;
      r[`VEOC_EV_SCALABLE_READ_ELEMENT_OPS*8 +: 8]  = sld_ops;
      r[`VEOC_EV_SCALABLE_WRITE_ELEMENT_OPS*8 +: 8] = sst_ops;
      r[`VEOC_EV_SCALABLE_MEM_ACCESS_ELEMENT_OPS*8 +: 8] = sld_ops + sst_ops;
      r[`VEOC_EV_SCALABLE_READ_BYTES*8 +: 8]        = sld_bytes;
      r[`VEOC_EV_SCALABLE_WRITE_BYTES*8 +: 8]       = sst_bytes;
      r[`VEOC_EV_SCALABLE_MEM_ACCESS_BYTES*8 +: 8]  = sld_bytes + sst_bytes;
      r[`VEOC_EV_FIXED_READ_BYTES*8 +: 8]           = ld_bytes;
      r[`VEOC_EV_FIXED_WRITE_BYTES*8 +: 8]          = st_bytes;
      r[`VEOC_EV_FIXED_MEM_ACCESS_BYTES*8 +: 8]     = ld_bytes + st_bytes;
      slot_increments = r;
    end
  endfunction

  genvar gs;
  genvar ge;
  generate
    for (gs = 0; gs < SLOTS; gs = gs + 1) begin : g_slot
      assign slot_inc[gs*ALL_INC_W +: ALL_INC_W] = slot_increments(
        slot_valid[gs],
        slot_class[2*gs +: 2],
        slot_scalable[gs],
        slot_vector[gs],
        slot_fused[gs],
        slot_mem_kind[3*gs +: 3],
        slot_store[gs],
        slot_container_element_bits_log[2*gs +: 2],
        slot_memory_element_bits_log[2*gs +: 2],
        slot_fixed_elements[5*gs +: 5],
        slot_registers[3*gs +: 3]);
    end
  endgenerate

  // Adding all slots in one cycle keeps counts exact at the cost of a wider adder.
  // Same-cycle summation.
  always @* begin
    next_cycle_increment = {(`VEOC_EVENT_COUNT*SUM_W){1'b0}};
    for (e = 0; e < `VEOC_EVENT_COUNT; e = e + 1) begin
      for (s = 0; s < SLOTS; s = s + 1) begin
        next_cycle_increment[e*SUM_W +: SUM_W] = next_cycle_increment[e*SUM_W +: SUM_W]
          + {{(SUM_W-`VEOC_INC_W){1'b0}}, slot_inc[s*ALL_INC_W + e*`VEOC_INC_W +: `VEOC_INC_W]};
      end
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      cycle_increment <= {(`VEOC_EVENT_COUNT*SUM_W){1'b0}};
    end else begin
      cycle_increment <= next_cycle_increment;
    end
  end

  generate
    for (ge = 0; ge < `VEOC_EVENT_COUNT; ge = ge + 1) begin : g_counter
      veoc_counter #(
        .CNT_W (CNT_W),
        .ADD_W (SUM_W)
      ) u_counter (
        .clock (clock),
        .rst   (rst),
        .clear (counter_clear),
        .add   (next_cycle_increment[ge*SUM_W +: SUM_W]),
        .count (event_count[ge*CNT_W +: CNT_W])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// File: sim/veoc_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module veoc_asserts #(
  parameter SLOTS = 2,
  parameter CNT_W = 64,
  parameter SUM_W = 12
) (
  input wire logic                clock,
  input wire logic                rst,
  input wire logic                counter_clear,
  input wire logic [SLOTS-1:0]    slot_valid,
  input wire logic [2*SLOTS-1:0]  slot_class,
  input wire logic [SLOTS-1:0]    slot_scalable,
  input wire logic [SLOTS-1:0]    slot_vector,
  input wire logic [SLOTS-1:0]    slot_fused,
  input wire logic [3*SLOTS-1:0]  slot_mem_kind,
  input wire logic [2*SLOTS-1:0]  slot_container_element_bits_log,
  input wire logic [16*SUM_W-1:0] cycle_increment,
  input wire logic [16*CNT_W-1:0] event_count
);
  // Per-op amounts are judged only for lone slot 0 issues; idle, sum and counter checks cover every cycle.
  wire              solo = slot_valid == 1;
  wire [1:0]        cls  = slot_class[1:0];
  wire [1:0]        csz  = slot_container_element_bits_log[1:0];
  wire [CNT_W-1:0]  cnt0 = event_count[CNT_W-1:0];
  logic [SUM_W-1:0] inc [16];
  always_comb begin
    for (int e = 0; e < 16; e++) begin
      inc[e] = cycle_increment[e*SUM_W +: SUM_W];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_idle_adds_nothing: assert property (slot_valid == 0 |=> cycle_increment == 0)
    else $error("increment with no valid slot");
  a_dp_scalable: assert property (solo && cls == 1 && slot_scalable[0]
    |=> inc[0] == ($past(slot_fused[0]) ? 4 : 2) && inc[1] == 0) else $error("scalable dp");
  a_dp_fixed: assert property (solo && cls == 1 && !slot_scalable[0] |=> inc[0] == 0
    && inc[1] == (($past(slot_vector[0]) ? 2 : 1) << $past(slot_fused[0]))) else $error("fixed dp");
  a_int_scalable: assert property (solo && cls == 2 && slot_scalable[0] && !slot_fused[0]
    |=> inc[2] == (16 >> $past(csz))) else $error("scalable integer");
  a_quad_read: assert property (solo && cls == 3 && slot_mem_kind[2:0] == 5
    |=> inc[6] == 0 && inc[7] == (16 >> $past(csz)) && inc[13] == 16) else $error("quad load");
  a_access_sum: assert property (inc[5] == inc[7] + inc[9] && inc[4] == inc[6] + inc[8]
    && inc[11] == inc[13] + inc[15] && inc[10] == inc[12] + inc[14]) else $error("access sum");
  a_count_adds: assert property (!$past(rst) && !$past(counter_clear)
    |-> cnt0 == $past(cnt0) + inc[0]) else $error("counter missed increment");
  a_clear_restarts: assert property (!$past(rst) && $past(counter_clear)
    |-> cnt0 == inc[0]) else $error("clear lost increment");
endmodule
bind veoc_event_counters veoc_asserts #(.SLOTS(SLOTS), .CNT_W(CNT_W), .SUM_W(SUM_W))
  i_veoc_asserts (
    .clock(clock),
    .rst(rst),
    .counter_clear(counter_clear),
    .slot_valid(slot_valid),
    .slot_class(slot_class),
    .slot_scalable(slot_scalable),
    .slot_vector(slot_vector),
    .slot_fused(slot_fused),
    .slot_mem_kind(slot_mem_kind),
    .slot_container_element_bits_log(slot_container_element_bits_log),
    .cycle_increment(cycle_increment),
    .event_count(event_count)
  );
`default_nettype wire

// File: sim/veoc_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
`define VEOC_QUAL {slot_class, slot_scalable, slot_vector, slot_fused, slot_mem_kind, \
  slot_store, slot_container_element_bits_log, slot_memory_element_bits_log, \
  slot_fixed_elements, slot_registers}
module veoc_pipe_model (
  output var logic [1:0] slot_valid,
  output var logic [3:0] slot_class,
  output var logic [1:0] slot_scalable,
  output var logic [1:0] slot_vector,
  output var logic [1:0] slot_fused,
  output var logic [5:0] slot_mem_kind,
  output var logic [1:0] slot_store,
  output var logic [3:0] slot_container_element_bits_log,
  output var logic [3:0] slot_memory_element_bits_log,
  output var logic [9:0] slot_fixed_elements,
  output var logic [5:0] slot_registers
);
  initial begin
    slot_valid = 2'h0;
    `VEOC_QUAL = '0;
  end
  // Issue one operation in slot s; callers step just after a falling edge.
  task automatic issue(input int s, input logic [1:0] cls, input logic sc, vec, fu,
      input logic [2:0] k, input logic st, input logic [1:0] csz, msz,
      input logic [4:0] el, input logic [2:0] rg);
    slot_valid[s] = 1'b1;
    {slot_class[2*s +: 2], slot_scalable[s], slot_vector[s], slot_fused[s]} = {cls, sc, vec, fu};
    {slot_mem_kind[3*s +: 3], slot_store[s], slot_fixed_elements[5*s +: 5]} = {k, st, el};
    {slot_container_element_bits_log[2*s +: 2], slot_memory_element_bits_log[2*s +: 2],
     slot_registers[3*s +: 3]} = {csz, msz, rg};
  endtask
  // Dropped slots show inverted fields, so nothing can lean on stale values.
  task automatic idle;
    slot_valid = 2'h0;
    `VEOC_QUAL = ~`VEOC_QUAL;
  endtask
endmodule
`default_nettype wire

// File: sim/veoc_event_counters_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch %0t got %0d want %0d", $time, a, b); end end
module veoc_event_counters_test;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  logic          counter_clear = 1'b0;
  logic [11:0]   x [16] = '{default: 12'h000};
  logic [63:0]   sum [16] = '{default: 64'h0};
  int            bad_count = 0;
  int            comparisons = 0;
  wire  [1:0]    slot_valid, slot_scalable, slot_vector, slot_fused, slot_store;
  wire  [3:0]    slot_class, slot_container_element_bits_log, slot_memory_element_bits_log;
  wire  [5:0]    slot_mem_kind, slot_registers;
  wire  [9:0]    slot_fixed_elements;
  wire  [191:0]  cycle_increment;
  wire  [1023:0] event_count;
  veoc_event_counters #(.SLOTS(2), .CNT_W(64), .SUM_W(12)) i_veoc_event_counters (
    .clock(clock),
    .rst(rst),
    .counter_clear(counter_clear),
    .slot_valid(slot_valid),
    .slot_class(slot_class),
    .slot_scalable(slot_scalable),
    .slot_vector(slot_vector),
    .slot_fused(slot_fused),
    .slot_mem_kind(slot_mem_kind),
    .slot_store(slot_store),
    .slot_container_element_bits_log(slot_container_element_bits_log),
    .slot_memory_element_bits_log(slot_memory_element_bits_log),
    .slot_fixed_elements(slot_fixed_elements),
    .slot_registers(slot_registers),
    .cycle_increment(cycle_increment),
    .event_count(event_count)
  );
  veoc_pipe_model i_veoc_pipe_model (
    .slot_valid(slot_valid),
    .slot_class(slot_class),
    .slot_scalable(slot_scalable),
    .slot_vector(slot_vector),
    .slot_fused(slot_fused),
    .slot_mem_kind(slot_mem_kind),
    .slot_store(slot_store),
    .slot_container_element_bits_log(slot_container_element_bits_log),
    .slot_memory_element_bits_log(slot_memory_element_bits_log),
    .slot_fixed_elements(slot_fixed_elements),
    .slot_registers(slot_registers)
  );
  // All sixteen events are compared every cycle, so a stray increment shows at once.
  task automatic run(input logic c = 1'b0);
    counter_clear = c;
    @(negedge clock);
    for (int i = 0; i < 16; i++) begin
      sum[i] = c ? 64'(x[i]) : sum[i] + 64'(x[i]);
      `CHK(cycle_increment[i*12 +: 12], x[i])
      `CHK(event_count[i*64 +: 64], sum[i])
      x[i] = 12'h000;
    end
  endtask
  task automatic op(input int e, v, input logic [1:0] cls, input logic sc, vec, fu,
      input logic [1:0] csz = 2'h3, input logic [4:0] el = 5'h05, input logic c = 1'b0);
    x[e] = 12'(v);
    i_veoc_pipe_model.issue(0, cls, sc, vec, fu, 3'h7, 1'b1, csz, 2'h3, el, 3'h4);
    run(c);
  endtask
  task automatic mem(input logic [2:0] k, input logic st, input logic [1:0] csz, msz,
      input logic [4:0] el, input logic [2:0] rg, input int sc, ro, wo, rb, wb);
    int b = sc ? 4 : 5;
    {x[b], x[b + 2], x[b + 4]} = {12'(ro + wo), 12'(ro), 12'(wo)};
    {x[b + 6], x[b + 8], x[b + 10]} = {12'(rb + wb), 12'(rb), 12'(wb)};
    i_veoc_pipe_model.issue(0, 2'h3, sc == 0, 1'b1, 1'b1, k, st, csz, msz, el, rg);
    run();
  endtask
  task automatic t_compute;
    op(0, 2, 1, 1, 0, 0);
    op(0, 4, 1, 1, 0, 1);
    op(1, 2, 1, 0, 1, 0);
    op(1, 4, 1, 0, 1, 1);
    op(1, 1, 1, 0, 0, 0);
    op(1, 2, 1, 0, 0, 1);
    for (int c = 0; c < 4; c++) op(2, 16 >> c, 2, 1, 0, 0, 2'(c));
    op(2, 4, 2, 1, 0, 1);
    op(3, 16, 2, 0, 1, 0, 2'h0, 5'h10);
    op(3, 6, 2, 0, 1, 1, 2'h0, 5'h03);
    op(3, 1, 2, 0, 0, 0);
    op(3, 2, 2, 0, 0, 1);
    $display("compute test done");
  endtask
  task automatic t_mem;
    mem(0, 0, 3, 3, 1, 1, 0, 1, 0, 8, 0);
    mem(0, 1, 3, 2, 1, 1, 0, 0, 1, 0, 4);
    mem(1, 0, 3, 3, 1, 1, 0, 2, 0, 16, 0);
    mem(1, 1, 3, 0, 1, 1, 0, 0, 2, 0, 2);
    mem(2, 0, 3, 2, 1, 1, 0, 1, 1, 4, 4);
    mem(3, 0, 3, 3, 1, 1, 0, 0, 1, 0, 8);
    mem(4, 0, 3, 1, 1, 1, 0, 1, 0, 2, 0);
    mem(5, 0, 2, 0, 1, 1, 0, 4, 0, 16, 0);
    mem(6, 0, 3, 2, 4, 3, 0, 12, 0, 48, 0);
    mem(6, 1, 3, 0, 16, 4, 0, 0, 64, 0, 64);
    mem(7, 0, 3, 0, 1, 2, 1, 4, 0, 4, 0);
    mem(7, 1, 0, 0, 1, 4, 1, 0, 64, 0, 64);
    mem(7, 0, 2, 2, 1, 1, 1, 4, 0, 16, 0);
    $display("memory test done");
  endtask
  task automatic t_dual;
    i_veoc_pipe_model.issue(1, 2'h1, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, 2'h0, 2'h0, 5'h00, 3'h1);
    op(0, 6, 1, 1, 0, 1);
    op(0, 6, 1, 1, 0, 1, 2'h3, 5'h05, 1'b1);
    i_veoc_pipe_model.idle();
    run();
    $display("dual test done");
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial forever #25 clock = ~clock;
  initial begin
    repeat (4) @(negedge clock);
    rst = 1'b0;
    @(negedge clock);
    t_compute();
    t_mem();
    t_dual();
    test_done();
  end
  // A stuck run is cut off and counted as a failure.
  initial begin
    repeat (200) @(posedge clock);
    bad_count++;
    test_done();
  end
endmodule
`default_nettype wire
